// File: core/cpm_pin_mux.sv
// Purpose: Assigns one internal function to each of five configurable pins
// Assumes: Status inputs come from logic on clk_i; pin inputs are external
// Notes:   Selection registers stand for the nonvolatile configuration
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defs.svh"

// Overview of operation
// - Each pin's function comes from its stored selection field, not pin state.
// - Factory selection: pin0 receive led, pin1 transmit led, pins 2-3 power.
// - Line driver enable selectable on all pins, active while serial transmits.
// - Power enable goes low once configured, high again during suspend.
// - Transmit indicator pulses low while USB transmits, otherwise high.
// - Receive indicator pulses low while USB receives, otherwise high.
// - Combined indicator pulses low on USB transmit or receive.
// - Sleep indicator low for the whole suspend, high otherwise.
// - Clock output functions drive one of four free-running divided clocks.
// - Pins 0-3 may each be general-purpose I/O; pin 4 may not.
// - Active-low write strobe in bit-bang modes, only on pins 0 or 1.
// - Active-low read strobe in bit-bang modes, on pins 0 to 3.
// - With option set, pins pull low while power off; else inputs pull up.
// - With option set, serial lines pull low while power enable is high.
module cpm_pin_mux
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Device state
    input  wire logic        usb_configured_i,
    input  wire logic        usb_suspend_i,
    input  wire logic        usb_tx_active_i,
    input  wire logic        usb_rx_active_i,
    input  wire logic        serial_tx_busy_i,
    input  wire logic        bitbang_mode_i,
    input  wire logic        gp_write_pulse_i,
    input  wire logic        gp_read_pulse_i,
    // Configurable pins
    input  wire logic [4:0]  cfg_pin_i,
    output logic      [4:0]  cfg_pin_o,
    output logic      [4:0]  cfg_pin_oe_n_o,
    output logic      [4:0]  cfg_pin_pull_up_o,
    output logic      [4:0]  cfg_pin_pull_down_o,
    // Serial interface bleed
    output logic             serial_pull_down_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam logic [`CPM_LED_CNT_W-1:0] LED_HOLD =
        `CPM_LED_CNT_W'(`CPM_LED_HOLD_CYC);

    logic [`CPM_PIN_SEL_W-1:0] pin_sel_q;
    logic                      opt_pulldn_q;
    logic [3:0]                gp_out_q;
    logic [3:0]                gp_dir_q;
    logic                      ack_q;
    logic [31:0]               dat_q;
    logic [31:0]               rd_data;
    logic                      req;
    logic                      wr_commit;
    logic [31:0]               wr_mask;
    logic [4:0]                pin_meta_q;
    logic [4:0]                pin_sync_q;
    cpm_pkg::cpm_pwr_state_t   pwr_state_q;
    cpm_pkg::cpm_pwr_state_t   pwr_state_d;
    logic                      pwr_en_n_q;
    logic                      pwr_en_n_d;
    logic                      susp_pull;
    logic [2:0]                act_raw;
    logic [2:0]                led_n;
    logic [3:0]                clk_div;
    logic [4:0]                pin_d;
    logic [4:0]                oe_n_d;
    logic [4:0]                pu_d;
    logic [4:0]                pd_d;
    logic                      wr_strobe_n;
    logic                      rd_strobe_n;

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    assign req       = wb_cyc_i & wb_stb_i;
    assign wr_commit = req & wb_we_i & ack_q;
    assign wr_mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    assign rd_data =
        (wb_adr_i == `CPM_ADR_PIN_SEL) ? {12'h000, pin_sel_q} :
        (wb_adr_i == `CPM_ADR_OPTIONS) ? {31'h0, opt_pulldn_q} :
        (wb_adr_i == `CPM_ADR_GP_CTRL) ? {24'h00, gp_dir_q, gp_out_q} :
        (wb_adr_i == `CPM_ADR_STATUS)  ?
            {23'h0, pin_sync_q, 1'b0, usb_configured_i, usb_suspend_i,
             pwr_en_n_q} :
        32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            dat_q <= (req & ~ack_q & ~wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Writes land at the edge where the master sees ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_sel_q    <= `CPM_PIN_SEL_RST;
            opt_pulldn_q <= 1'b0;
            gp_out_q     <= 4'h0;
            gp_dir_q     <= 4'h0;
        end
        else if (wr_commit)
        begin
            if (wb_adr_i == `CPM_ADR_PIN_SEL)
                pin_sel_q <= (pin_sel_q & ~wr_mask[19:0])
                           | (wb_dat_i[19:0] & wr_mask[19:0]);
            if (wb_adr_i == `CPM_ADR_OPTIONS && wb_sel_i[0])
                opt_pulldn_q <= wb_dat_i[`CPM_OPT_PULLDN_BIT];
            if (wb_adr_i == `CPM_ADR_GP_CTRL && wb_sel_i[0])
            begin
                gp_out_q <= wb_dat_i[3:0];
                gp_dir_q <= wb_dat_i[`CPM_GP_DIR_LSB+3:`CPM_GP_DIR_LSB];
            end
        end
    end

    // ************************************************************
    // Pin input synchroniser
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_q <= 5'h00;
            pin_sync_q <= 5'h00;
        end
        else
        begin
            pin_meta_q <= cfg_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ************************************************************
    // Power enable sequencing
    // ************************************************************
    always_comb
    begin
        pwr_state_d = pwr_state_q;
        unique case (pwr_state_q)
            cpm_pkg::CPM_PS_UNCONF:
                if (usb_configured_i)
                    pwr_state_d = usb_suspend_i ? cpm_pkg::CPM_PS_SUSPEND
                                                : cpm_pkg::CPM_PS_ON;
            cpm_pkg::CPM_PS_ON:
                if (!usb_configured_i)
                    pwr_state_d = cpm_pkg::CPM_PS_UNCONF;
                else if (usb_suspend_i)
                    pwr_state_d = cpm_pkg::CPM_PS_SUSPEND;
            cpm_pkg::CPM_PS_SUSPEND:
                if (!usb_configured_i)
                    pwr_state_d = cpm_pkg::CPM_PS_UNCONF;
                else if (!usb_suspend_i)
                    pwr_state_d = cpm_pkg::CPM_PS_ON;
        endcase
    end

    assign pwr_en_n_d = (pwr_state_d != cpm_pkg::CPM_PS_ON);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pwr_state_q <= cpm_pkg::CPM_PS_UNCONF;
            pwr_en_n_q  <= 1'b1;
        end
        else
        begin
            pwr_state_q <= pwr_state_d;
            pwr_en_n_q  <= pwr_en_n_d;
        end
    end

    assign susp_pull = opt_pulldn_q & pwr_en_n_q;

    // ************************************************************
    // Activity indicators: tx, rx, combined
    // ************************************************************
    assign act_raw = {usb_tx_active_i | usb_rx_active_i,
                      usb_rx_active_i,
                      usb_tx_active_i};

    for (genvar k = 0; k < 3; k++)
    begin : g_led
        logic [`CPM_LED_CNT_W-1:0] hold_q;
        logic                      act;

        // Idle until configured, then stretch each burst to a visible pulse
        assign act      = act_raw[k] & usb_configured_i;
        assign led_n[k] = ~(act | (hold_q != '0));

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                hold_q <= '0;
            else if (act)
                hold_q <= LED_HOLD;
            else if (hold_q != '0)
                hold_q <= hold_q - 1'b1;
        end
    end

    // ************************************************************
    // Divided clocks and strobes
    // ************************************************************
    cpm_clk_div u_clk_div
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clk_div_o (clk_div)
    );

    assign wr_strobe_n = ~(bitbang_mode_i & gp_write_pulse_i);
    assign rd_strobe_n = ~(bitbang_mode_i & gp_read_pulse_i);

    // ************************************************************
    // Per-pin function selection
    // ************************************************************
    for (genvar p = 0; p < `CPM_NUM_PINS; p++)
    begin : g_pin
        cpm_pkg::cpm_func_t func;

        assign func = cpm_pkg::cpm_func_t'(pin_sel_q[p*4 +: 4]);

        always_comb
        begin
            pin_d[p]  = 1'b1;
            oe_n_d[p] = 1'b0;
            unique case (func)
                cpm_pkg::CPM_F_LINE_DRV: pin_d[p] = ~serial_tx_busy_i;
                cpm_pkg::CPM_F_PWR_EN:   pin_d[p] = pwr_en_n_d;
                cpm_pkg::CPM_F_TX_LED:   pin_d[p] = led_n[0];
                cpm_pkg::CPM_F_RX_LED:   pin_d[p] = led_n[1];
                cpm_pkg::CPM_F_ANY_LED:  pin_d[p] = led_n[2];
                cpm_pkg::CPM_F_SLEEP:    pin_d[p] = ~usb_suspend_i;
                cpm_pkg::CPM_F_CLK_DIV1: pin_d[p] = clk_div[0];
                cpm_pkg::CPM_F_CLK_DIV2: pin_d[p] = clk_div[1];
                cpm_pkg::CPM_F_CLK_DIV4: pin_d[p] = clk_div[2];
                cpm_pkg::CPM_F_CLK_DIV8: pin_d[p] = clk_div[3];
                cpm_pkg::CPM_F_GP_IO:
                    if (p < `CPM_NUM_GP_PINS)
                    begin
                        pin_d[p]  = gp_out_q[p % 4];
                        oe_n_d[p] = ~gp_dir_q[p % 4];
                    end
                    else
                        oe_n_d[p] = 1'b1;
                cpm_pkg::CPM_F_GP_WR:
                    if (p < 2)
                        pin_d[p] = wr_strobe_n;
                    else
                        oe_n_d[p] = 1'b1;
                cpm_pkg::CPM_F_GP_RD:
                    if (p < `CPM_NUM_GP_PINS)
                        pin_d[p] = rd_strobe_n;
                    else
                        oe_n_d[p] = 1'b1;
                default:
                    oe_n_d[p] = 1'b1;
            endcase
        end

        // With option set, bleed low while power is off, else inputs float high
        assign pd_d[p] = susp_pull;
        assign pu_d[p] = oe_n_d[p] & ~susp_pull;
    end

    // ************************************************************
    // Output flops
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_pin_o           <= 5'h1F;
            cfg_pin_oe_n_o      <= 5'h00;
            cfg_pin_pull_up_o   <= 5'h00;
            cfg_pin_pull_down_o <= 5'h00;
            serial_pull_down_o  <= 1'b0;
        end
        else
        begin
            cfg_pin_o           <= pin_d;
            cfg_pin_oe_n_o      <= oe_n_d;
            cfg_pin_pull_up_o   <= pu_d;
            cfg_pin_pull_down_o <= pd_d;
            serial_pull_down_o  <= susp_pull;
        end
    end

endmodule

`default_nettype wire

// File: core/cpm_defs.svh
// Purpose: Constants of the configurable pin function multiplexer
// Assumes: Wishbone byte addresses, 32-bit data, 50 MHz clock
// Notes:   Register offsets, field layouts, reset values, timing counts
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define CPM_ADR_PIN_SEL     8'h00
`define CPM_ADR_OPTIONS     8'h04
`define CPM_ADR_GP_CTRL     8'h08
`define CPM_ADR_STATUS      8'h0C

// ************************************************************
// Field layout and reset values
// ************************************************************
`define CPM_NUM_PINS        5
`define CPM_NUM_GP_PINS     4
`define CPM_SEL_W           4
`define CPM_PIN_SEL_W       20
// Pin 0 receive led, pin 1 transmit led, pins 2/3 power, pin 4 sleep
`define CPM_PIN_SEL_RST     20'h5_1123
`define CPM_OPT_PULLDN_BIT  0
`define CPM_GP_DIR_LSB      4
`define CPM_ST_PWR_BIT      0
`define CPM_ST_SUSP_BIT     1
`define CPM_ST_CONF_BIT     2
`define CPM_ST_PIN_LSB      4

// ************************************************************
// Timing
// ************************************************************
`define CPM_CLK_PERIOD_NS   20
`define CPM_LED_HOLD_NS     20000
`define CPM_LED_HOLD_CYC    (`CPM_LED_HOLD_NS / `CPM_CLK_PERIOD_NS)
`define CPM_LED_CNT_W       10

`endif

// File: core/cpm_pkg.sv
// Purpose: Types of the configurable pin function multiplexer
// Assumes: Field codes follow the order of the enum
// Notes:   Codes 13 to 15 of a selection field are illegal
package cpm_pkg;

    // ************************************************************
    // Pin function selection
    // ************************************************************
    typedef enum logic [3:0] {
        CPM_F_LINE_DRV,
        CPM_F_PWR_EN,
        CPM_F_TX_LED,
        CPM_F_RX_LED,
        CPM_F_ANY_LED,
        CPM_F_SLEEP,
        CPM_F_CLK_DIV1,
        CPM_F_CLK_DIV2,
        CPM_F_CLK_DIV4,
        CPM_F_CLK_DIV8,
        CPM_F_GP_IO,
        CPM_F_GP_WR,
        CPM_F_GP_RD
    } cpm_func_t;

    // ************************************************************
    // Power enable sequencing
    // ************************************************************
    typedef enum logic [1:0] {
        CPM_PS_UNCONF,
        CPM_PS_ON,
        CPM_PS_SUSPEND
    } cpm_pwr_state_t;

endpackage

// File: core/cpm_clk_div.sv
// Purpose: Free-running divided clocks for the clock output functions
// Assumes: Runs from reset on every rising edge of clk_i
// Notes:   Bit k of clk_div_o toggles every 2**k cycles
`timescale 1ns/1ps
`default_nettype none

module cpm_clk_div
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Divided clocks: div1, div2, div4, div8
    output logic [3:0]      clk_div_o
);

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    assign cnt_d     = cnt_q + 4'h1;
    assign clk_div_o = cnt_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_d;
    end

endmodule

`default_nettype wire

// File: tb/cpm_pin_mux_props.sv
// Purpose: Assertions on the ports of the pin multiplexer
// Assumes: Selection and option shadowed from observed bus writes
// Notes:   Pin checks wait three cycles after reset
`timescale 1ns/1ps
`default_nettype none
`include "cpm_defs.svh"

module cpm_pin_mux_props
(
    // Clock, reset and bus
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Device state
    input  wire logic        usb_configured_i,
    input  wire logic        usb_suspend_i,
    input  wire logic        usb_tx_active_i,
    input  wire logic        serial_tx_busy_i,
    // Pins
    input  wire logic [4:0]  cfg_pin_o,
    input  wire logic [4:0]  cfg_pin_oe_n_o,
    input  wire logic [4:0]  cfg_pin_pull_down_o
);
    // ************
    // Shadow of the configuration
    // ************
    logic [19:0] sel_q;
    logic        opt_q;
    logic [1:0]  up_q;
    wire         wr_w  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    wire         psel_w = wr_w & (wb_adr_i == `CPM_ADR_PIN_SEL);
    wire         opt_w = wr_w & (wb_adr_i == `CPM_ADR_OPTIONS) & wb_sel_i[0];
    wire         pon_w = usb_configured_i & ~usb_suspend_i;
    wire         ok_w  = (up_q == 2'h3);
    wire [19:0]  sel_d = {wb_sel_i[2] ? wb_dat_i[19:16] : sel_q[19:16],
                          wb_sel_i[1] ? wb_dat_i[15:8] : sel_q[15:8],
                          wb_sel_i[0] ? wb_dat_i[7:0] : sel_q[7:0]};

    always_ff @(posedge clk_i)
    begin
        sel_q <= rst_i ? `CPM_PIN_SEL_RST : (psel_w ? sel_d : sel_q);
        opt_q <= rst_i ? 1'h0 : (opt_w ? wb_dat_i[0] : opt_q);
        up_q  <= rst_i ? 2'h0 : up_q + {1'h0, ~ok_w};
    end

    // ************
    // Properties
    // ************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_tx;
        ok_w && usb_tx_active_i && usb_configured_i && sel_q[7:4] == 4'h2;
    endsequence

    a_ack_next:
        assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_dat_idle:
        assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_power_pin:
        assert property (ok_w && $past(sel_q[11:8]) == 4'h1
            |-> cfg_pin_o[2] == !$past(pon_w)) else $error("power pin");
    a_sleep_pin:
        assert property (ok_w && $past(sel_q[19:16]) == 4'h5
            |-> cfg_pin_o[4] == !$past(usb_suspend_i)) else $error("sleep");
    a_line_drv:
        assert property (ok_w && $past(sel_q[3:0]) == 4'h0
            |-> cfg_pin_o[0] == !$past(serial_tx_busy_i)
            && !cfg_pin_oe_n_o[0]) else $error("line driver pin");
    a_clk_toggle:
        assert property (ok_w && $past(sel_q[3:0], 2) == 4'h6
            && $past(sel_q[3:0]) == 4'h6 |-> cfg_pin_o[0] != $past(cfg_pin_o[0]))
        else $error("clock pin still");
    a_led_hold:
        assert property (s_tx |=> (!cfg_pin_o[1]) [*8]) else $error("tx led");
    a_pull_dn:
        assert property (ok_w && $past(opt_q) && !$past(pon_w, 2)
            |-> cfg_pin_pull_down_o == 5'h1F) else $error("pull down");
    a_gp_refused:
        assert property (ok_w && $past(sel_q[19:16]) == 4'hA
            |-> cfg_pin_oe_n_o[4]) else $error("gp io on pin 4");
endmodule

bind cpm_pin_mux cpm_pin_mux_props u_props (.*);
`default_nettype wire

// File: tb/cpm_pin_far.sv
// Purpose: Outside circuitry on the five configurable pins
// Assumes: Nothing outside drives a pin the device leaves undriven
// Notes:   A floating pin with no pull shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none

module cpm_pin_far
(
    // Clock
    input  wire logic       clk_i,
    // Device side of each pin
    input  wire logic [4:0] drv_i,
    input  wire logic [4:0] oe_n_i,
    input  wire logic [4:0] pull_up_i,
    input  wire logic [4:0] pull_down_i,
    // Level on each wire
    output logic      [4:0] level_o
);
    logic [4:0] last_q;
    wire  [4:0] float_w = pull_up_i | ~pull_down_i & ~last_q;

    assign level_o = ~oe_n_i & drv_i | oe_n_i & float_w;

    always_ff @(posedge clk_i)
    begin
        last_q <= level_o;
    end
endmodule
`default_nettype wire

// File: tb/cpm_pin_mux_test.sv
// Purpose: Self-checking bench of the configurable pin multiplexer
// Assumes: Inputs change by non-blocking assignment after rising edges
// Notes:   Pin outputs are sampled on falling edges, the reset idle pin checks on a rising edge, bus read data on the rising edge after ack
`timescale 1ns/1ps
`default_nettype none

module cpm_pin_mux_test;
    logic        clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic        conf = 1'h0, susp = 1'h0, txa = 1'h0, rxa = 1'h0;
    logic        busy = 1'h0, bbm = 1'h0, wpl = 1'h0, rpl = 1'h0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000, dat_o, q;
    logic        ack, spd;
    logic [4:0]  pin, oe_n, pu, pd, lvl;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    cpm_pin_mux dut_u
    (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .usb_configured_i(conf),
        .usb_suspend_i(susp), .usb_tx_active_i(txa), .usb_rx_active_i(rxa),
        .serial_tx_busy_i(busy), .bitbang_mode_i(bbm),
        .gp_write_pulse_i(wpl), .gp_read_pulse_i(rpl), .cfg_pin_i(lvl),
        .cfg_pin_o(pin), .cfg_pin_oe_n_o(oe_n), .cfg_pin_pull_up_o(pu),
        .cfg_pin_pull_down_o(pd), .serial_pull_down_o(spd)
    );

    cpm_pin_far far_u
    (
        .clk_i(clk), .drv_i(pin), .oe_n_i(oe_n), .pull_up_i(pu),
        .pull_down_i(pd), .level_o(lvl)
    );

    initial
    begin
        forever #10 clk = ~clk;
    end

    // ************
    // Shared tasks
    // ************
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we  <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (ack !== 1'h1 && n < 16);
        if (ack !== 1'h1)
        begin
            n_mismatch++;
            results();
        end
        @(posedge clk);
        q = dat_o;
        cyc <= 1'h0;
        stb <= 1'h0;
        we  <= 1'h0;
    endtask

    // ************
    // Scenarios
    // ************
    task automatic t_reset();
        wb(1'h0, 8'h00, 4'hF, 32'h0000_0000);
        chk("pin_sel", 32'h0005_1123, q);
        wb(1'h0, 8'h04, 4'hF, 32'h0000_0000);
        chk("options", 32'h0000_0000, q);
        wb(1'h0, 8'h10, 4'hF, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, q);
        chk("pins_idle", 32'h0000_001F, 32'(pin));
        chk("oe_n", 32'h0000_0000, 32'(oe_n));
        $display("test reset done");
    endtask

    task automatic t_power();
        @(posedge clk);
        conf <= 1'h1;
        tk(3);
        chk("power_on", 32'h0000_0004, 32'(pin[4:2]));
        @(posedge clk);
        susp <= 1'h1;
        tk(3);
        chk("power_susp", 32'h0000_0003, 32'(pin[4:2]));
        wb(1'h1, 8'h04, 4'hF, 32'h0000_0001);
        tk(2);
        chk("pull_dn", 32'h0000_003F, 32'({spd, pd}));
        @(posedge clk);
        susp <= 1'h0;
        tk(3);
        chk("pull_off", 32'h0000_0000, 32'({spd, pd}));
        wb(1'h1, 8'h04, 4'hF, 32'h0000_0000);
        $display("test power done");
    endtask

    task automatic t_leds();
        wb(1'h1, 8'h00, 4'h4, 32'h0004_0000);
        wb(1'h0, 8'h00, 4'hF, 32'h0000_0000);
        chk("sel_lanes", 32'h0004_1123, q);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            txa <= (k == 0);
            rxa <= (k == 1);
            @(posedge clk);
            txa <= 1'h0;
            rxa <= 1'h0;
            tk(992);
            chk("led_on", 32'(k + 1), 32'(pin));
            tk(20);
            chk("led_off", 32'h0000_0013, 32'(pin));
        end
        $display("test leds done");
    endtask

    task automatic t_codes();
        logic p;
        int   c;
        for (int k = 0; k < 4; k++)
        begin
            wb(1'h1, 8'h00, 4'hF, 32'h0004_1126 + k);
            tk(2);
            c = 0;
            p = pin[0];
            repeat (64)
            begin
                tk(1);
                c += int'(pin[0] !== p);
                p = pin[0];
            end
            chk("clk_div", 32'(64 >> k), 32'(c));
        end
        wb(1'h1, 8'h00, 4'hF, 32'h0004_1120);
        @(posedge clk);
        busy <= 1'h1;
        tk(2);
        chk("line_drv", 32'h0000_0000, 32'(pin[0]));
        @(posedge clk);
        busy <= 1'h0;
        tk(2);
        chk("line_idle", 32'h0000_0001, 32'(pin[0]));
        wb(1'h1, 8'h08, 4'hF, 32'h0000_0011);
        wb(1'h1, 8'h00, 4'hF, 32'h000A_112A);
        tk(2);
        chk("gp_out", 32'h0000_0005, 32'({oe_n[4], oe_n[0], pin[0]}));
        wb(1'h1, 8'h08, 4'hF, 32'h0000_0000);
        tk(4);
        wb(1'h0, 8'h0C, 4'hF, 32'h0000_0000);
        chk("gp_in", 32'h0000_0014, q & 32'h0000_0017);
        $display("test codes done");
    endtask

    task automatic t_strobes();
        wb(1'h1, 8'h00, 4'hF, 32'h000C_CBBB);
        @(posedge clk);
        bbm <= 1'h1;
        wpl <= 1'h1;
        tk(2);
        chk("wr_strobe", 32'h0000_0004, 32'({pin[3], pin[1:0]}));
        chk("refused", 32'h0000_0014, 32'(oe_n));
        chk("pull_up", 32'h0000_0014, 32'(pu));
        @(posedge clk);
        wpl <= 1'h0;
        rpl <= 1'h1;
        tk(2);
        chk("rd_strobe", 32'h0000_0003, 32'({pin[3], pin[1:0]}));
        @(posedge clk);
        bbm <= 1'h0;
        tk(2);
        chk("no_mode", 32'h0000_0007, 32'({pin[3], pin[1:0]}));
        $display("test strobes done");
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_power();
        t_leds();
        t_codes();
        t_strobes();
        results();
    end
endmodule
`default_nettype wire
